// File: hdl/cmd_top.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

module cmd_top (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [cmd_pkg::ADDR_W-1:0] PADDR,
   input wire logic [cmd_pkg::DATA_W-1:0] PWDATA,
   output logic [cmd_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CTRL_TX,
   input wire logic PORT_OUT_DATA,
   input wire logic PORT_OUT_EN,
   output logic PORT_IN_LEVEL,
   input wire logic SHARED_PORT_LINE_I,
   output logic SHARED_PORT_LINE_O,
   output logic SHARED_PORT_LINE_OE,
   input wire logic BUS_RECEIVE_PIN,
   output logic RX_LEVEL,
   output logic TX_PIN_SELECT,
   output logic RX_IRQ_ENABLE,
   input wire logic ENG_REQ,
   input wire logic ENG_WE,
   input wire logic [cmd_pkg::MBOX_IDX_W-1:0] ENG_MBOX,
   input wire logic [cmd_pkg::BYTE_IDX_W-1:0] ENG_BYTE,
   input wire logic [cmd_pkg::BYTE_W-1:0] ENG_WDATA,
   output logic ENG_ACK,
   output logic [cmd_pkg::BYTE_W-1:0] ENG_RD_DATA
);

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------

   // Sorts a bus address into the region it selects.
   function automatic cmd_pkg::cmd_region_t region_of(input logic [cmd_pkg::ADDR_W-1:0] a);
      if (a[1:0] != cmd_pkg::WORD_ALIGN)
         return cmd_pkg::RG_NONE;
      else if (a >= cmd_pkg::MBOX_BASE && a < cmd_pkg::MBOX_END)
         return cmd_pkg::RG_MBOX;
      else if (a == cmd_pkg::MON_OFFSET)
         return cmd_pkg::RG_MON;
      else if (a == cmd_pkg::IRQ_OFFSET)
         return cmd_pkg::RG_IRQ;
      else
         return cmd_pkg::RG_NONE;
   endfunction : region_of

   // Turns a bus address into the storage index {mailbox, byte}.
   function automatic logic [cmd_pkg::RAM_IDX_W-1:0] ram_index(
      input logic [cmd_pkg::ADDR_W-1:0] a);
      return {a[cmd_pkg::MBOX_LSB +: cmd_pkg::MBOX_IDX_W],
              a[cmd_pkg::BYTE_LSB +: cmd_pkg::BYTE_IDX_W]};
   endfunction : ram_index

   // ------------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;
   logic [1:0] pins_sync;
   logic tx_lvl;
   logic rx_lvl;

   // Reset asserts at once and releases two edges later.
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         rst_meta_q <= 1'h0;
         rst_n_q <= 1'h0;
      end
      else
      begin
         rst_meta_q <= 1'h1;
         rst_n_q <= rst_meta_q;
      end
   end

   cmd_pin_sync #(
      .W(2)
   ) u_pin_sync (
      .clk(MCLK),
      .rst_n(rst_n_q),
      .d({SHARED_PORT_LINE_I, BUS_RECEIVE_PIN}),
      .q(pins_sync)
   );

   assign tx_lvl = pins_sync[1];
   assign rx_lvl = pins_sync[0];

   // ------------------------------------------------------------------
   // Bus slave and control registers
   // ------------------------------------------------------------------
   cmd_pkg::cmd_apb_state_t st_q, st_d;
   cmd_pkg::cmd_region_t reg_sel;
   logic [cmd_pkg::DATA_W-1:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic halt_q, halt_d;
   logic sel_q, sel_d;
   logic irqen_q, irqen_d;
   logic access;
   logic apb_start;
   logic apb_ram_rd;
   logic apb_ram_wr;
   logic [cmd_pkg::BYTE_W-1:0] ram_rdata;

   assign reg_sel = region_of(PADDR);
   assign access = PSEL && PENABLE;
   // Mailbox accesses wait while the engine asks for the storage port.
   assign apb_start = (st_q == cmd_pkg::ST_IDLE) && access
                      && !(reg_sel == cmd_pkg::RG_MBOX && ENG_REQ);
   assign apb_ram_rd = apb_start && !PWRITE && reg_sel == cmd_pkg::RG_MBOX;
   // Writes land only on the edge at which the master sees PREADY.
   assign apb_ram_wr = (st_q == cmd_pkg::ST_RESP) && PWRITE && reg_sel == cmd_pkg::RG_MBOX;

   // Next values of the slave state, read data and control bits.
   always_comb
   begin
      st_d = st_q;
      prdata_d = prdata_q;
      pready_d = 1'h0;
      pslverr_d = 1'h0;
      halt_d = halt_q;
      sel_d = sel_q;
      irqen_d = irqen_q;
      unique case (st_q)
         cmd_pkg::ST_IDLE:
         begin
            if (apb_start)
            begin
               prdata_d = cmd_pkg::ZERO_WORD;
               pready_d = !apb_ram_rd;
               pslverr_d = reg_sel == cmd_pkg::RG_NONE;
               st_d = apb_ram_rd ? cmd_pkg::ST_READ : cmd_pkg::ST_RESP;
               if (!PWRITE && reg_sel == cmd_pkg::RG_MON)
               begin
                  prdata_d[cmd_pkg::HALT_BIT] = halt_q;
                  prdata_d[cmd_pkg::SEL_BIT] = sel_q;
                  prdata_d[cmd_pkg::TXPIN_BIT] = tx_lvl;
                  prdata_d[cmd_pkg::RXPIN_BIT] = rx_lvl;
               end
               if (!PWRITE && reg_sel == cmd_pkg::RG_IRQ)
               begin
                  prdata_d[cmd_pkg::IRQEN_BIT] = irqen_q;
               end
            end
         end
         cmd_pkg::ST_READ:
         begin
            prdata_d = {{(cmd_pkg::DATA_W-cmd_pkg::BYTE_W){1'h0}}, ram_rdata};
            pready_d = 1'h1;
            st_d = cmd_pkg::ST_RESP;
         end
         cmd_pkg::ST_RESP:
         begin
            st_d = cmd_pkg::ST_IDLE;
            if (PWRITE && reg_sel == cmd_pkg::RG_MON)
            begin
               halt_d = PWDATA[cmd_pkg::HALT_BIT];
               sel_d = PWDATA[cmd_pkg::SEL_BIT];
            end
            if (PWRITE && reg_sel == cmd_pkg::RG_IRQ)
            begin
               irqen_d = PWDATA[cmd_pkg::IRQEN_BIT];
            end
         end
      endcase
   end

   // Registers of the bus slave and control bits.
   always_ff @(posedge MCLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         st_q <= cmd_pkg::ST_IDLE;
         prdata_q <= cmd_pkg::ZERO_WORD;
         pready_q <= 1'h0;
         pslverr_q <= 1'h0;
         halt_q <= cmd_pkg::HALT_RST;
         sel_q <= cmd_pkg::SEL_RST;
         irqen_q <= cmd_pkg::IRQEN_RST;
      end
      else
      begin
         st_q <= st_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         halt_q <= halt_d;
         sel_q <= sel_d;
         irqen_q <= irqen_d;
      end
   end

   // ------------------------------------------------------------------
   // Storage port shared by the bus and the engine
   // ------------------------------------------------------------------
   logic eng_take;
   logic eng_pend_q, eng_pend_d;
   logic eng_ack_q, eng_ack_d;
   logic [cmd_pkg::BYTE_W-1:0] eng_data_q, eng_data_d;
   logic ram_we;
   logic [cmd_pkg::RAM_IDX_W-1:0] ram_addr;
   logic [cmd_pkg::BYTE_W-1:0] ram_wdata;

   // A bus write on its completion edge owns the port; the engine is next.
   assign eng_take = ENG_REQ && !eng_pend_q && !eng_ack_q && !apb_ram_wr;

   // Port steering; engine byte 0 is the first data byte on the wire.
   always_comb
   begin
      ram_we = 1'h0;
      ram_addr = ram_index(PADDR);
      ram_wdata = PWDATA[cmd_pkg::BYTE_W-1:0];
      if (apb_ram_wr)
      begin
         ram_we = 1'h1;
      end
      else if (eng_take)
      begin
         ram_we = ENG_WE;
         ram_addr = {ENG_MBOX, ENG_BYTE};
         ram_wdata = ENG_WDATA;
      end
   end

   cmd_mbox_ram #(
      .MBOXES(cmd_pkg::MBOX_COUNT),
      .BYTES(cmd_pkg::MBOX_BYTES),
      .DW(cmd_pkg::BYTE_W),
      .AW(cmd_pkg::RAM_IDX_W)
   ) u_mbox_ram (
      .clk(MCLK),
      .rst_n(rst_n_q),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   // Engine handshake: taken, then acknowledged with data one edge later.
   always_comb
   begin
      eng_pend_d = eng_take;
      eng_ack_d = eng_pend_q;
      eng_data_d = eng_pend_q ? ram_rdata : eng_data_q;
   end

   always_ff @(posedge MCLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         eng_pend_q <= 1'h0;
         eng_ack_q <= 1'h0;
         eng_data_q <= '0;
      end
      else
      begin
         eng_pend_q <= eng_pend_d;
         eng_ack_q <= eng_ack_d;
         eng_data_q <= eng_data_d;
      end
   end

   // ------------------------------------------------------------------
   // Pin drive and level outputs
   // ------------------------------------------------------------------
   logic pin_o_q, pin_o_d;
   logic pin_oe_q, pin_oe_d;
   logic rx_out_q, port_in_q;

   // With the TX pin select set, the halt holds the line recessive so a stuck controller cannot jam the bus.
   always_comb
   begin
      if (sel_q)
      begin
         pin_o_d = halt_q ? cmd_pkg::RECESSIVE : CTRL_TX;
         pin_oe_d = 1'h1;
      end
      else
      begin
         pin_o_d = PORT_OUT_DATA;
         pin_oe_d = PORT_OUT_EN;
      end
   end

   always_ff @(posedge MCLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pin_o_q <= cmd_pkg::RECESSIVE;
         pin_oe_q <= 1'h0;
         rx_out_q <= cmd_pkg::RECESSIVE;
         port_in_q <= cmd_pkg::RECESSIVE;
      end
      else
      begin
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         rx_out_q <= rx_lvl;
         port_in_q <= tx_lvl;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign SHARED_PORT_LINE_O = pin_o_q;
   assign SHARED_PORT_LINE_OE = pin_oe_q;
   assign PORT_IN_LEVEL = port_in_q;
   assign RX_LEVEL = rx_out_q;
   assign TX_PIN_SELECT = sel_q;
   assign RX_IRQ_ENABLE = irqen_q;
   assign ENG_ACK = eng_ack_q;
   assign ENG_RD_DATA = eng_data_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_halt_forces_high : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      (sel_q && halt_q) |=> (SHARED_PORT_LINE_O && SHARED_PORT_LINE_OE))
      else $error("Halted transmit line was not held high.");

   a_normal_tx_path : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      (sel_q && !halt_q) |=> (SHARED_PORT_LINE_O == $past(CTRL_TX)))
      else $error("Transmit line did not follow the controller output.");

   a_port_mode_path : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      !sel_q |=> (SHARED_PORT_LINE_O == $past(PORT_OUT_DATA)
                  && SHARED_PORT_LINE_OE == $past(PORT_OUT_EN)))
      else $error("Shared line did not follow the general port.");

   a_mon_tx_level : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      (apb_start && !PWRITE && reg_sel == cmd_pkg::RG_MON)
      |=> (PREADY && PRDATA[cmd_pkg::TXPIN_BIT] == $past(tx_lvl)))
      else $error("Monitor read did not show the transmit pin level.");

   a_mon_rx_level : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      (apb_start && !PWRITE && reg_sel == cmd_pkg::RG_MON)
      |=> (PRDATA[cmd_pkg::RXPIN_BIT] == $past(rx_lvl)))
      else $error("Monitor read did not show the receive pin level.");

   a_mon_reserved_zero : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      (apb_start && !PWRITE && reg_sel == cmd_pkg::RG_MON)
      |=> (PRDATA[31:7] == 25'h0000000 && PRDATA[4:2] == 3'h0))
      else $error("Reserved monitor bits did not read as zero.");

   a_mon_write_fields : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      (st_q == cmd_pkg::ST_RESP && PWRITE && reg_sel == cmd_pkg::RG_MON)
      |=> (halt_q == $past(PWDATA[cmd_pkg::HALT_BIT])
           && TX_PIN_SELECT == $past(PWDATA[cmd_pkg::SEL_BIT])))
      else $error("Monitor write did not update halt and select.");

   a_irq_enable_write : assert property (
      @(posedge MCLK) disable iff (!rst_n_q)
      (st_q == cmd_pkg::ST_RESP && PWRITE && reg_sel == cmd_pkg::RG_IRQ)
      |=> (RX_IRQ_ENABLE == $past(PWDATA[cmd_pkg::IRQEN_BIT])))
      else $error("Receive interrupt enable did not take the written value.");

endmodule : cmd_top

// File: hdl/cmd_pkg.sv
package cmd_pkg;

   // ------------------------------------------------------------------
   // Storage geometry
   // ------------------------------------------------------------------
   localparam int MBOX_COUNT = 16;
   localparam int MBOX_BYTES = 8;
   localparam int BYTE_W = 8;
   localparam int MBOX_IDX_W = 4;
   localparam int BYTE_IDX_W = 3;
   localparam int RAM_IDX_W = MBOX_IDX_W + BYTE_IDX_W;

   // ------------------------------------------------------------------
   // Bus map
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Mailbox m, data byte n (1..8) sits at m*0x20 + (n-1)*4.
   localparam logic [ADDR_W-1:0] MBOX_BASE = 12'h000;
   localparam logic [ADDR_W-1:0] MBOX_END = 12'h200;
   localparam int MBOX_LSB = 5;
   localparam int BYTE_LSB = 2;
   localparam logic [ADDR_W-1:0] MON_OFFSET = 12'h200;
   localparam logic [ADDR_W-1:0] IRQ_OFFSET = 12'h204;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // ------------------------------------------------------------------
   // Monitor and receive interrupt control fields
   // ------------------------------------------------------------------
   localparam int HALT_BIT = 6;
   localparam int SEL_BIT = 5;
   localparam int TXPIN_BIT = 1;
   localparam int RXPIN_BIT = 0;
   localparam int IRQEN_BIT = 0;
   localparam logic HALT_RST = 1'h0;
   localparam logic SEL_RST = 1'h0;
   localparam logic IRQEN_RST = 1'h0;
   localparam logic RECESSIVE = 1'h1;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {RG_MBOX, RG_MON, RG_IRQ, RG_NONE} cmd_region_t;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_RESP} cmd_apb_state_t;

endpackage : cmd_pkg

// File: hdl/cmd_pin_sync.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Two-stage synchroniser for pin levels
// ---------------------------------------------------------------------
module cmd_pin_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // Only the second stage is visible; the first may be metastable.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '1;
         q <= '1;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule : cmd_pin_sync

// File: hdl/cmd_mbox_ram.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Mailbox data storage, one byte per location
// ---------------------------------------------------------------------
module cmd_mbox_ram #(
   parameter int MBOXES = cmd_pkg::MBOX_COUNT,
   parameter int BYTES = cmd_pkg::MBOX_BYTES,
   parameter int DW = cmd_pkg::BYTE_W,
   parameter int AW = cmd_pkg::RAM_IDX_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [MBOXES*BYTES];
   logic [AW-1:0] last_addr_q;
   logic [DW-1:0] last_data_q;
   logic last_valid_q;

   // Plain storage with no reset, so contents start unknown. Reads return
   // the old byte when the same location is written in the same cycle.
   always_ff @(posedge clk)
   begin
      rdata <= mem[addr];
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   // Helper that remembers the last write, read only by the check below.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_valid_q <= 1'h0;
         last_addr_q <= '0;
         last_data_q <= '0;
      end
      else if (we)
      begin
         last_valid_q <= 1'h1;
         last_addr_q <= addr;
         last_data_q <= wdata;
      end
   end

   a_ram_read_back : assert property (
      @(posedge clk) disable iff (!rst_n)
      (last_valid_q && !we && addr == last_addr_q) |=> (rdata == $past(last_data_q)))
      else $error("Mailbox byte did not read back the value last written.");

endmodule : cmd_mbox_ram

// File: tb/cmd_xcvr_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Bus transceiver on the shared transmit line and the receive pin
// ---------------------------------------------------------------------
module cmd_xcvr_model (
   input wire logic txd_o,
   input wire logic txd_oe,
   input wire logic other_dom,
   output logic line,
   output logic rxd
);
   // The shared line has a pull-up, so an undriven line reads recessive.
   assign line = txd_oe ? txd_o : 1'h1;
   // Wired-AND bus: any dominant node pulls the receive level low.
   assign rxd = line & ~other_dom;
endmodule : cmd_xcvr_model

// File: tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic mclk = 1'h0;
   logic arst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, ctrl_tx = 1'h1, pod = 1'h1, poe = 1'h0, pin_lvl;
   logic line, line_o, line_oe, rxd, rx_lvl, sel, irq_en, dom = 1'h0;
   logic ereq = 1'h0, ewe = 1'h0, eack;
   logic [3:0] embox = 4'h0;
   logic [2:0] ebyte = 3'h0;
   logic [7:0] ewd = 8'h00, erd;
   int failures = 0;
   int checks = 0;
   logic [31:0] r;
   logic e;

   always #50 mclk = ~mclk;

   cmd_top uut (.MCLK(mclk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CTRL_TX(ctrl_tx), .PORT_OUT_DATA(pod), .PORT_OUT_EN(poe),
      .PORT_IN_LEVEL(pin_lvl), .SHARED_PORT_LINE_I(line), .SHARED_PORT_LINE_O(line_o),
      .SHARED_PORT_LINE_OE(line_oe), .BUS_RECEIVE_PIN(rxd), .RX_LEVEL(rx_lvl),
      .TX_PIN_SELECT(sel), .RX_IRQ_ENABLE(irq_en), .ENG_REQ(ereq), .ENG_WE(ewe),
      .ENG_MBOX(embox), .ENG_BYTE(ebyte), .ENG_WDATA(ewd), .ENG_ACK(eack),
      .ENG_RD_DATA(erd));

   cmd_xcvr_model xcvr (.txd_o(line_o), .txd_oe(line_oe), .other_dom(dom), .line(line),
      .rxd(rxd));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task finish_test;
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // Reset is held twelve edges; the synchroniser needs two more, and the task waits three.
   task do_reset;
      @(posedge mclk);
      arst_n <= 1'h0;
      repeat (12) @(posedge mclk);
      arst_n <= 1'h1;
      repeat (3) @(posedge mclk);
   endtask : do_reset

   // One APB transfer; request is held until PREADY is seen at an edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'h1 && n < 60);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 60)
      begin
         failures++;
         finish_test();
      end
   endtask : apb

   // Engine access, held until the acknowledge pulse is sampled.
   task eng(input logic w, input logic [3:0] m, input logic [2:0] b, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      ereq <= 1'h1;
      ewe <= w;
      embox <= m;
      ebyte <= b;
      ewd <= d;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (eack !== 1'h1 && n < 60);
      r = {24'h000000, erd};
      ereq <= 1'h0;
      if (n >= 60)
      begin
         failures++;
         finish_test();
      end
   endtask : eng

   function automatic logic [7:0] pat(int m, int b);
      return 8'(m * 8 + b) ^ 8'hA5;
   endfunction : pat

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Fill every byte of every mailbox, then read all back.
   task sc_mailbox;
      for (int m = 0; m < 16; m++)
         for (int b = 0; b < 8; b++)
            apb(1'h1, 12'(m * 32 + b * 4), {24'hFFFFFF, pat(m, b)});
      for (int m = 0; m < 16; m++)
         for (int b = 0; b < 8; b++)
         begin
            apb(1'h0, 12'(m * 32 + b * 4), 32'h0000_0000);
            chk(r, {24'h000000, pat(m, b)}, "mailbox byte");
         end
   endtask : sc_mailbox

   // Engine byte 0 is the first stored byte, indices rising upward.
   task sc_engine;
      eng(1'h0, 4'h3, 3'h0, 8'h00);
      chk(r, {24'h000000, pat(3, 0)}, "engine first byte");
      eng(1'h1, 4'hF, 3'h7, 8'h5C);
      apb(1'h0, 12'h1FC, 32'h0000_0000);
      chk(r, 32'h0000_005C, "engine last byte");
   endtask : sc_engine

   // Monitor defaults, write masks and the pin controls.
   task sc_monitor;
      apb(1'h0, 12'h200, 32'h0000_0000);
      chk(r, 32'h0000_0003, "monitor reset");
      apb(1'h1, 12'h200, 32'h0000_00FF);
      repeat (4) @(posedge mclk);
      apb(1'h0, 12'h200, 32'h0000_0000);
      chk(r, 32'h0000_0063, "monitor masks");
      ctrl_tx <= 1'h0;
      repeat (4) @(posedge mclk);
      chk({31'h0, line_o}, 32'h1, "halt holds line");
      chk({31'h0, line_oe}, 32'h1, "select drives");
      apb(1'h1, 12'h200, 32'h0000_0020);
      dom <= 1'h1;
      repeat (4) @(posedge mclk);
      apb(1'h0, 12'h200, 32'h0000_0000);
      chk(r, 32'h0000_0020, "tx and rx low");
      chk({31'h0, rx_lvl}, 32'h0, "rx level");
      apb(1'h1, 12'h200, 32'h0000_0000);
      pod <= 1'h0;
      poe <= 1'h1;
      dom <= 1'h0;
      repeat (4) @(posedge mclk);
      chk({30'h0, line_oe, line_o}, 32'h2, "port owns line");
      chk({30'h0, sel, pin_lvl}, 32'h0, "port level");
      apb(1'h0, 12'h200, 32'h0000_0000);
      chk(r, 32'h0000_0000, "tx pin reads port");
      poe <= 1'h0;
   endtask : sc_monitor

   // Receive interrupt enable and an unmapped access.
   task sc_irq_err;
      apb(1'h1, 12'h204, 32'h0000_0001);
      @(posedge mclk);
      chk({31'h0, irq_en}, 32'h1, "irq enable");
      apb(1'h1, 12'h204, 32'h0000_0000);
      @(posedge mclk);
      chk({31'h0, irq_en}, 32'h0, "irq disable");
      apb(1'h0, 12'h300, 32'h0000_0000);
      chk({31'h0, e}, 32'h1, "unmapped error");
      chk(r, 32'h0000_0000, "unmapped data");
   endtask : sc_irq_err

   // A reset in mid-run clears the controls but keeps stored bytes.
   task sc_rereset;
      apb(1'h1, 12'h200, 32'h0000_0060);
      do_reset();
      apb(1'h0, 12'h200, 32'h0000_0000);
      chk(r, 32'h0000_0003, "monitor after reset");
      apb(1'h0, 12'h0A8, 32'h0000_0000);
      chk(r, {24'h000000, pat(5, 2)}, "byte kept");
   endtask : sc_rereset

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      do_reset();
      sc_monitor();
      sc_mailbox();
      sc_engine();
      sc_irq_err();
      sc_rereset();
      finish_test();
   end
endmodule : tb_top
